// ---- rtl/pmux_pkg.sv ----
// package: offsets, field positions, channel indices and carriers for the timer pin mux
package pmux_pkg;
    // avalon byte offsets of the registers
    localparam logic [5:0] OFF_P2_DIR = 6'h00;
    localparam logic [5:0] OFF_P3_DIR = 6'h04;
    localparam logic [5:0] OFF_WSEL0 = 6'h08;
    localparam logic [5:0] OFF_WSEL1 = 6'h0C;
    localparam logic [5:0] OFF_CSEL1 = 6'h10;
    localparam logic [5:0] OFF_PSEL = 6'h14;
    localparam logic [5:0] OFF_PULLUP = 6'h18;
    localparam logic [5:0] OFF_P2_DRV = 6'h1C;
    localparam logic [5:0] OFF_GEN_DRV = 6'h20;
    localparam logic [5:0] OFF_P2_DATA = 6'h24;
    localparam logic [5:0] OFF_P3_DATA = 6'h28;
    localparam logic [5:0] OFF_PIN_STATE = 6'h2C;
    // every register is one byte in lane 0, reset to zero
    localparam logic [7:0] REG_RST = 8'h00;
    // field positions
    localparam int WAVE_D0_BIT = 0;
    localparam int WAVE_B0_LSB = 2;
    localparam int WAVE_C0_LSB = 4;
    localparam int WAVE_A1_BIT = 0;
    localparam int WAVE_B1_BIT = 1;
    localparam int CMP_C_LSB = 0;
    localparam int CMP_D_LSB = 4;
    localparam int PULSE_OUT_BIT = 0;
    localparam int PU_BIT_FOUR = 4;
    localparam int PU_BIT_FIVE = 5;
    localparam int PU_BIT_SIX = 6;
    localparam int DRV_BIT_SIX = 6;
    localparam int P3_PIN_BIT = 1;
    // select codes that hand a pin to a timer channel
    localparam logic [1:0] WAVE_SEL_CODE = 2'h2;
    localparam logic [2:0] CMP_SEL_CODE = 3'h4;
    // pin index: port-2 bits 1..5, then port-3 bit 1
    localparam int PIN_P21 = 0;
    localparam int PIN_P22 = 1;
    localparam int PIN_P23 = 2;
    localparam int PIN_P24 = 3;
    localparam int PIN_P25 = 4;
    localparam int PIN_P31 = 5;
    localparam int NUM_PINS = 6;
    // timer channel index inside the carriers
    localparam int CH_WAVE_C0 = 0;
    localparam int CH_CMP_C = 1;
    localparam int CH_WAVE_B0 = 2;
    localparam int CH_CMP_D = 3;
    localparam int CH_WAVE_D0 = 4;
    localparam int CH_WAVE_A1 = 5;
    localparam int CH_WAVE_B1 = 6;
    localparam int CH_PULSE = 7;
    localparam int NUM_CH = 8;
    // what the timers drive toward the pins
    typedef struct packed {
        logic [NUM_CH-1:0] val; // level per channel
        logic [NUM_CH-1:0] oe;  // channel wants to drive
    } pmux_tmr_drv_t;
endpackage

// ---- rtl/pmux_pin_cell.sv ----
// one pad slice: chooses general port or timer, registers the pad controls
`timescale 1ns/1ps
module pmux_pin_cell (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_sel,      // a timer owns this pin
    input wire logic i_per_out,  // timer level
    input wire logic i_per_oe,   // timer drive request
    input wire logic i_dir,      // direction bit, 1 = output
    input wire logic i_gpio_out, // port data latch
    input wire logic i_pin_in,   // pad level
    input wire logic i_pu_en,    // pull-up group control
    input wire logic i_drv_en,   // high drive control
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_pullup,
    output logic o_hidrive,
    output logic o_pin_level
);
    // a timer owner ignores direction on output; otherwise the direction bit rules
    wire nxt_oe = i_sel ? i_per_oe : i_dir;
    wire nxt_out = i_sel ? i_per_out : i_gpio_out;

    // pad controls, all registered so the pad sees no decode glitches
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_pin_out <= 1'b0;
            o_pin_oe <= 1'b0;
            o_pullup <= 1'b0;
            o_hidrive <= 1'b0;
            o_pin_level <= 1'b0;
        end else begin
            o_pin_out <= nxt_out;
            o_pin_oe <= nxt_oe;
            o_pullup <= i_pu_en & ~nxt_oe;  // pull-up only on input use
            o_hidrive <= i_drv_en & nxt_oe; // drive strength only on output use
            o_pin_level <= i_pin_in;
        end
    end
endmodule // pmux_pin_cell

// ---- rtl/pmux_top.sv ----
// timer pin mux for port-2 bits 1..5 and port-3 bit 1, with avalon register slave
`timescale 1ns/1ps
module pmux_top (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [5:0] i_avs_address, // byte address
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [5:0] i_pin_in,
    output logic [5:0] o_pin_out,
    output logic [5:0] o_pin_oe,
    output logic [5:0] o_pin_pullup,
    output logic [5:0] o_pin_hidrive,
    input wire pmux_pkg::pmux_tmr_drv_t i_tmr_drv,
    output logic [7:0] o_tmr_in
);
    // every register is one byte in lane 0; upper write lanes are dropped
    // software registers
    logic [7:0] p2_dir_ff;   // port2_direction
    logic [7:0] p3_dir_ff;   // port3_direction
    logic [7:0] wsel0_ff;    // wavetimer_pin_select_0
    logic [7:0] wsel1_ff;    // wavetimer_pin_select_1
    logic [7:0] csel1_ff;    // cmptimer_pin_select_1
    logic [7:0] psel_ff;     // pulsetimer_pin_select
    logic [7:0] pullup_ff;   // pullup_control_reg
    logic [7:0] p2_drv_ff;   // port2_drive_reg
    logic [7:0] gen_drv_ff;  // general_drive_reg
    logic [7:0] p2_data_ff;  // port-2 output latch
    logic [7:0] p3_data_ff;  // port-3 output latch
    logic [5:0] pin_level;   // registered pad levels from the cells

    // decode helpers, one per code, since each code is tested twice
    // compare the 2-bit wave select against its routing code
    function automatic logic pmux_wave_on(input logic [1:0] f);
        pmux_wave_on = (f == pmux_pkg::WAVE_SEL_CODE);
    endfunction

    // compare the 3-bit compare select against its routing code
    function automatic logic pmux_cmp_on(input logic [2:0] f);
        pmux_cmp_on = (f == pmux_pkg::CMP_SEL_CODE);
    endfunction

    // ---- select decode ----
    // unused bits of these registers are stored and read back only
    wire [1:0] wave_c0_select = wsel0_ff[pmux_pkg::WAVE_C0_LSB +: 2];
    wire [1:0] wave_b0_select = wsel0_ff[pmux_pkg::WAVE_B0_LSB +: 2];
    wire wave_d0_select = wsel0_ff[pmux_pkg::WAVE_D0_BIT];
    wire wave_a1_select = wsel1_ff[pmux_pkg::WAVE_A1_BIT];
    wire wave_b1_select = wsel1_ff[pmux_pkg::WAVE_B1_BIT];
    wire [2:0] cmp_c_select = csel1_ff[pmux_pkg::CMP_C_LSB +: 3];
    wire [2:0] cmp_d_select = csel1_ff[pmux_pkg::CMP_D_LSB +: 3];
    wire pulse_out_select = psel_ff[pmux_pkg::PULSE_OUT_BIT];

    // compare timer has priority over the wave timer on shared pins
    // masking the loser keeps two timers from fighting over one pad
    wire cmp_c_on = pmux_cmp_on(cmp_c_select);
    wire wave_c0_on = pmux_wave_on(wave_c0_select) & ~cmp_c_on;
    wire cmp_d_on = pmux_cmp_on(cmp_d_select);
    wire wave_b0_on = pmux_wave_on(wave_b0_select) & ~cmp_d_on;

    // per-channel ownership, indexed like the carrier
    wire [7:0] ch_on = {pulse_out_select, wave_b1_select, wave_a1_select,
                        wave_d0_select, cmp_d_on, wave_b0_on, cmp_c_on, wave_c0_on};

    // which pin each channel lands on
    wire [7:0][2:0] ch_pin = {3'(pmux_pkg::PIN_P31), 3'(pmux_pkg::PIN_P25),
                              3'(pmux_pkg::PIN_P24), 3'(pmux_pkg::PIN_P23),
                              3'(pmux_pkg::PIN_P22), 3'(pmux_pkg::PIN_P22),
                              3'(pmux_pkg::PIN_P21), 3'(pmux_pkg::PIN_P21)};

    // per-pin steering into the cells
    // sel_periph picks the timer path in the cell, per_oe its drive
    wire [5:0] sel_periph;
    wire [5:0] per_out;
    wire [5:0] per_oe;

    // P2_1: compare C or wave C0
    assign sel_periph[pmux_pkg::PIN_P21] = cmp_c_on | wave_c0_on;
    assign per_out[pmux_pkg::PIN_P21] = cmp_c_on ? i_tmr_drv.val[pmux_pkg::CH_CMP_C]
                                                 : i_tmr_drv.val[pmux_pkg::CH_WAVE_C0];
    assign per_oe[pmux_pkg::PIN_P21] = cmp_c_on ? i_tmr_drv.oe[pmux_pkg::CH_CMP_C]
                                                : i_tmr_drv.oe[pmux_pkg::CH_WAVE_C0];
    // P2_2: compare D or wave B0
    assign sel_periph[pmux_pkg::PIN_P22] = cmp_d_on | wave_b0_on;
    assign per_out[pmux_pkg::PIN_P22] = cmp_d_on ? i_tmr_drv.val[pmux_pkg::CH_CMP_D]
                                                 : i_tmr_drv.val[pmux_pkg::CH_WAVE_B0];
    assign per_oe[pmux_pkg::PIN_P22] = cmp_d_on ? i_tmr_drv.oe[pmux_pkg::CH_CMP_D]
                                                : i_tmr_drv.oe[pmux_pkg::CH_WAVE_B0];
    // single-owner pins
    // P2_3, P2_4 and P2_5 have one timer each, no priority needed
    assign sel_periph[pmux_pkg::PIN_P23] = wave_d0_select;
    assign per_out[pmux_pkg::PIN_P23] = i_tmr_drv.val[pmux_pkg::CH_WAVE_D0];
    assign per_oe[pmux_pkg::PIN_P23] = i_tmr_drv.oe[pmux_pkg::CH_WAVE_D0];
    assign sel_periph[pmux_pkg::PIN_P24] = wave_a1_select;
    assign per_out[pmux_pkg::PIN_P24] = i_tmr_drv.val[pmux_pkg::CH_WAVE_A1];
    assign per_oe[pmux_pkg::PIN_P24] = i_tmr_drv.oe[pmux_pkg::CH_WAVE_A1];
    assign sel_periph[pmux_pkg::PIN_P25] = wave_b1_select;
    assign per_out[pmux_pkg::PIN_P25] = i_tmr_drv.val[pmux_pkg::CH_WAVE_B1];
    assign per_oe[pmux_pkg::PIN_P25] = i_tmr_drv.oe[pmux_pkg::CH_WAVE_B1];
    // pulse output always drives once selected, direction ignored
    assign sel_periph[pmux_pkg::PIN_P31] = pulse_out_select;
    assign per_out[pmux_pkg::PIN_P31] = i_tmr_drv.val[pmux_pkg::CH_PULSE];
    assign per_oe[pmux_pkg::PIN_P31] = 1'b1;

    // direction, data latch, pull-up and drive groups per pin
    // port-2 bit 0 and the other port-3 bits serve pins outside this block
    // one pull-up bit covers a group of pins, hence the repeats below
    wire [5:0] dir = {p3_dir_ff[pmux_pkg::P3_PIN_BIT], p2_dir_ff[5:1]};
    wire [5:0] gpio_out = {p3_data_ff[pmux_pkg::P3_PIN_BIT], p2_data_ff[5:1]};
    wire pu4 = pullup_ff[pmux_pkg::PU_BIT_FOUR];
    wire pu5 = pullup_ff[pmux_pkg::PU_BIT_FIVE];
    wire pu6 = pullup_ff[pmux_pkg::PU_BIT_SIX];
    wire [5:0] pu_en = {pu6, pu5, pu5, pu4, pu4, pu4};
    wire [5:0] drv_en = {gen_drv_ff[pmux_pkg::DRV_BIT_SIX], p2_drv_ff[5:1]};

    // one registered pad slice per pin
    // registering in the cell costs a cycle but keeps glitches off pads
    genvar gi;
    generate
        for (gi = 0; gi < pmux_pkg::NUM_PINS; gi++) begin : g_pin
            pmux_pin_cell u_cell (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_sel(sel_periph[gi]),
                .i_per_out(per_out[gi]),
                .i_per_oe(per_oe[gi]),
                .i_dir(dir[gi]),
                .i_gpio_out(gpio_out[gi]),
                .i_pin_in(i_pin_in[gi]),
                .i_pu_en(pu_en[gi]),
                .i_drv_en(drv_en[gi]),
                .o_pin_out(o_pin_out[gi]),
                .o_pin_oe(o_pin_oe[gi]),
                .o_pullup(o_pin_pullup[gi]),
                .o_hidrive(o_pin_hidrive[gi]),
                .o_pin_level(pin_level[gi])
            );
        end
    endgenerate

    // timer inputs see the pad only when owned and direction is input;
    // the pulse timer has no input, so its slot is held low
    logic [7:0] nxt_tmr_in;
    always_comb begin
        nxt_tmr_in = '0;
        // channel k only listens to its own pin
        for (int k = 0; k < pmux_pkg::CH_PULSE; k++) begin
            nxt_tmr_in[k] = ch_on[k] & ~dir[ch_pin[k]] & i_pin_in[ch_pin[k]];
        end
    end

    // registered timer input levels
    // no synchroniser here: pin inputs count as clock-synchronous
    always_ff @(posedge i_mclk) begin
        if (i_rst) o_tmr_in <= '0;
        else o_tmr_in <= nxt_tmr_in;
    end

    // ---- avalon slave: one wait cycle, then the access completes ----
    // limitation: every access costs two cycles; no pipelining or bursts
    wire req = i_avs_read | i_avs_write;
    wire done = req & ~o_avs_waitrequest;          // edge where master sees wait low
    wire wr_lane0 = i_avs_write & done & i_avs_byteenable[0];
    wire [7:0] wbyte = i_avs_writedata[7:0];
    wire wr_p2_dir = wr_lane0 & (i_avs_address == pmux_pkg::OFF_P2_DIR);
    wire wr_p3_dir = wr_lane0 & (i_avs_address == pmux_pkg::OFF_P3_DIR);
    wire wr_wsel0 = wr_lane0 & (i_avs_address == pmux_pkg::OFF_WSEL0);
    wire wr_wsel1 = wr_lane0 & (i_avs_address == pmux_pkg::OFF_WSEL1);
    wire wr_csel1 = wr_lane0 & (i_avs_address == pmux_pkg::OFF_CSEL1);
    wire wr_psel = wr_lane0 & (i_avs_address == pmux_pkg::OFF_PSEL);
    wire wr_pullup = wr_lane0 & (i_avs_address == pmux_pkg::OFF_PULLUP);
    wire wr_p2_drv = wr_lane0 & (i_avs_address == pmux_pkg::OFF_P2_DRV);
    wire wr_gen_drv = wr_lane0 & (i_avs_address == pmux_pkg::OFF_GEN_DRV);
    wire wr_p2_data = wr_lane0 & (i_avs_address == pmux_pkg::OFF_P2_DATA);
    wire wr_p3_data = wr_lane0 & (i_avs_address == pmux_pkg::OFF_P3_DATA);

    // read mux; unmapped offsets and upper bytes read as zero
    // no error response: a bad offset is silently refused
    logic [7:0] rd_byte;
    always_comb begin
        case (i_avs_address)
            pmux_pkg::OFF_P2_DIR: rd_byte = p2_dir_ff;
            pmux_pkg::OFF_P3_DIR: rd_byte = p3_dir_ff;
            pmux_pkg::OFF_WSEL0: rd_byte = wsel0_ff;
            pmux_pkg::OFF_WSEL1: rd_byte = wsel1_ff;
            pmux_pkg::OFF_CSEL1: rd_byte = csel1_ff;
            pmux_pkg::OFF_PSEL: rd_byte = psel_ff;
            pmux_pkg::OFF_PULLUP: rd_byte = pullup_ff;
            pmux_pkg::OFF_P2_DRV: rd_byte = p2_drv_ff;
            pmux_pkg::OFF_GEN_DRV: rd_byte = gen_drv_ff;
            pmux_pkg::OFF_P2_DATA: rd_byte = p2_data_ff;
            pmux_pkg::OFF_P3_DATA: rd_byte = p3_data_ff;
            pmux_pkg::OFF_PIN_STATE: rd_byte = {2'b00, pin_level};
            default: rd_byte = pmux_pkg::REG_RST;
        endcase
    end

    // handshake: wait drops for exactly one cycle per request
    // read data are captured on the first edge so they stand while wait is low
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= '0;
        end else begin
            // a request seen while wait is high opens the one-cycle window
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            if (i_avs_read & o_avs_waitrequest) o_avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // register writes; all reset to zero so every pin starts as a plain input
    // a write lands only on the edge where the master sees wait low
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            // reset: no selects, every direction bit an input
            p2_dir_ff <= pmux_pkg::REG_RST;
            p3_dir_ff <= pmux_pkg::REG_RST;
            wsel0_ff <= pmux_pkg::REG_RST;
            wsel1_ff <= pmux_pkg::REG_RST;
            csel1_ff <= pmux_pkg::REG_RST;
            psel_ff <= pmux_pkg::REG_RST;
            pullup_ff <= pmux_pkg::REG_RST;
            p2_drv_ff <= pmux_pkg::REG_RST;
            gen_drv_ff <= pmux_pkg::REG_RST;
            p2_data_ff <= pmux_pkg::REG_RST;
            p3_data_ff <= pmux_pkg::REG_RST;
        end else begin
            // otherwise only the addressed register changes
            if (wr_p2_dir) p2_dir_ff <= wbyte;
            if (wr_p3_dir) p3_dir_ff <= wbyte;
            if (wr_wsel0) wsel0_ff <= wbyte;
            if (wr_wsel1) wsel1_ff <= wbyte;
            if (wr_csel1) csel1_ff <= wbyte;
            if (wr_psel) psel_ff <= wbyte;
            if (wr_pullup) pullup_ff <= wbyte;
            if (wr_p2_drv) p2_drv_ff <= wbyte;
            if (wr_gen_drv) gen_drv_ff <= wbyte;
            if (wr_p2_data) p2_data_ff <= wbyte;
            if (wr_p3_data) p3_data_ff <= wbyte;
        end
    end

    // ---- checks ----
    // pads lag their causes by one clock, so most checks use |=> and $past
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // routing and priority
    a_gpio_dir_out: assert property (
        !sel_periph[pmux_pkg::PIN_P23] |=> o_pin_oe[pmux_pkg::PIN_P23] == $past(dir[2]))
        else $error("gpio pin oe does not follow direction");

    a_c0_route_out: assert property (
        wave_c0_on |=> o_pin_out[0] == $past(i_tmr_drv.val[pmux_pkg::CH_WAVE_C0]))
        else $error("wave c0 not on pin P2_1");

    a_cmp_c_wins: assert property (
        cmp_c_on |=> o_pin_oe[0] == $past(i_tmr_drv.oe[pmux_pkg::CH_CMP_C]))
        else $error("compare C lost priority on P2_1");

    a_cmp_d_wins: assert property (
        cmp_d_on |=> o_pin_out[1] == $past(i_tmr_drv.val[pmux_pkg::CH_CMP_D]))
        else $error("compare D lost priority on P2_2");

    // timer input gating and pulse output drive
    a_c0_input_path: assert property (
        (wave_c0_on && !dir[0]) |=> o_tmr_in[pmux_pkg::CH_WAVE_C0] == $past(i_pin_in[0]))
        else $error("wave c0 input not routed");

    a_cmp_c_input: assert property (
        cmp_c_on |=> !o_tmr_in[pmux_pkg::CH_WAVE_C0])
        else $error("wave c0 input seen while compare C owns P2_1");

    a_a1_input_path: assert property (
        (wave_a1_select && !dir[3]) |=> o_tmr_in[pmux_pkg::CH_WAVE_A1] == $past(i_pin_in[3]))
        else $error("wave a1 input not routed");

    a_b1_input_gate: assert property (
        (dir[4] || !wave_b1_select) |=> !o_tmr_in[pmux_pkg::CH_WAVE_B1])
        else $error("wave b1 input seen without ownership");

    a_pulse_drives: assert property (
        pulse_out_select |=> o_pin_oe[5] && o_pin_out[5] == $past(per_out[5]))
        else $error("pulse output not driven");

    // pull-up and drive strength
    a_pullup_four: assert property (
        o_pin_pullup[2] |-> $past(pu4) && !o_pin_oe[2])
        else $error("P2_3 pull-up without bit four");

    a_pullup_five: assert property (
        (pu5 && !per_oe[3] && !dir[3]) |=> o_pin_pullup[3])
        else $error("P2_4 pull-up missing");

    a_pullup_six: assert property (
        o_pin_pullup[5] |-> $past(pu6))
        else $error("P3_1 pull-up without bit six");

    a_p2_hidrive: assert property (
        o_pin_hidrive[0] |-> $past(p2_drv_ff[1]) && o_pin_oe[0])
        else $error("P2_1 high drive without its bit");

    a_p3_hidrive: assert property (
        (gen_drv_ff[pmux_pkg::DRV_BIT_SIX] && pulse_out_select) |=> o_pin_hidrive[5])
        else $error("P3_1 high drive missing");

    // reset and bus handshake
    a_reset_input: assert property (
        $past(i_rst) |-> o_pin_oe == '0 && o_tmr_in == '0)
        else $error("pins not inputs after reset");

    a_bus_one_wait: assert property (
        (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest not one-cycle");

    // scenarios the bench is expected to reach
    c_cmp_over_wave: cover property (cmp_c_on && pmux_wave_on(wave_c0_select));
    c_a1_input: cover property ((wave_a1_select && !dir[3]) ##1 o_tmr_in[pmux_pkg::CH_WAVE_A1]);
    c_pulse_out: cover property (pulse_out_select ##1 o_pin_oe[5]);
    c_bus_write: cover property (wr_csel1);
    c_timer_input: cover property (o_tmr_in[pmux_pkg::CH_WAVE_B0]);
endmodule // pmux_top

// ---- verif/pmux_far_model.sv ----
// board-side pad model: resolves device drive, board drive and pull-up
`timescale 1ns/1ps
module pmux_far_model (
    input wire logic i_mclk,
    input wire logic [5:0] i_pin_out,
    input wire logic [5:0] i_pin_oe,
    input wire logic [5:0] i_pin_pullup,
    input wire logic [5:0] i_board_val,
    input wire logic i_board_en,
    output logic [5:0] o_pad
);
    logic [5:0] float_ff = 6'h00; // level of an undriven pad
    // an undriven pad wanders every cycle so a stale value never passes
    always @(posedge i_mclk) begin
        float_ff <= ~o_pad;
    end
    // device drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (i_pin_oe[i]) o_pad[i] = i_pin_out[i];
            else if (i_board_en) o_pad[i] = i_board_val[i];
            else if (i_pin_pullup[i]) o_pad[i] = 1'b1;
            else o_pad[i] = float_ff[i];
        end
    end
endmodule // pmux_far_model

// ---- verif/pmux_top_tb_top.sv ----
// self-checking bench for the timer pin mux
`timescale 1ns/1ps
module pmux_top_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_be = 4'h1;
    logic [31:0] avs_wdata = 32'h0000_0000;
    logic [31:0] rd_data;
    logic wait_req;
    logic [5:0] pad, pin_out, pin_oe, pin_pu, pin_hd;
    logic [5:0] board_val = 6'h00; // level the board drives
    logic board_en = 1'b1; // board drives released pads
    pmux_pkg::pmux_tmr_drv_t tmr = '0;
    logic [7:0] tmr_in;
    logic [7:0] regs [0:10]; // shadow of the writable registers
    int err_total = 0;
    int checked = 0;

    // 10 mhz clock
    always #50 mclk = ~mclk;

    pmux_top uut (.i_mclk(mclk), .i_rst(rst), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_byteenable(avs_be),
        .i_avs_writedata(avs_wdata), .o_avs_readdata(rd_data),
        .o_avs_waitrequest(wait_req), .i_pin_in(pad), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_pin_pullup(pin_pu), .o_pin_hidrive(pin_hd),
        .i_tmr_drv(tmr), .o_tmr_in(tmr_in));
    pmux_far_model u_far (.i_mclk(mclk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .i_pin_pullup(pin_pu), .i_board_val(board_val), .i_board_en(board_en),
        .o_pad(pad));

    // verdict and end of run
    task automatic stop_test;
        $display("counts: %0d checks, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon access; held until waitrequest is sampled low
    task automatic bus_op(input logic wr, input logic [5:0] a, input logic [7:0] d,
        input logic be0, output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_wdata <= {24'h00_0000, d};
        avs_be <= {3'b000, be0};
        // the watchdog alone ends a wait that never finishes
        do begin
            @(posedge mclk);
        end while (wait_req !== 1'b0);
        q = rd_data;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk); // keeps the next request off this time step
    endtask

    task automatic wr_reg(input int k, input logic [7:0] v);
        logic [31:0] q;
        bus_op(1'b1, 6'(k * 4), v, 1'b1, q);
        regs[k] = v;
    endtask

    // expected pad state from the shadow registers and timer drive
    function automatic logic [31:0] expect_pads();
        logic [5:0] own, oe, out, pu, hd, pd;
        logic [7:0] tin;
        int ch [0:5];
        logic d;
        own[0] = regs[4][2:0] == 3'h4 || regs[2][5:4] == 2'h2;
        ch[0] = (regs[4][2:0] == 3'h4) ? pmux_pkg::CH_CMP_C : pmux_pkg::CH_WAVE_C0;
        own[1] = regs[4][6:4] == 3'h4 || regs[2][3:2] == 2'h2;
        ch[1] = (regs[4][6:4] == 3'h4) ? pmux_pkg::CH_CMP_D : pmux_pkg::CH_WAVE_B0;
        own[2] = regs[2][0];
        ch[2] = pmux_pkg::CH_WAVE_D0;
        own[3] = regs[3][0];
        ch[3] = pmux_pkg::CH_WAVE_A1;
        own[4] = regs[3][1];
        ch[4] = pmux_pkg::CH_WAVE_B1;
        own[5] = regs[5][0];
        ch[5] = pmux_pkg::CH_PULSE;
        tin = 8'h00;
        for (int i = 0; i < 6; i++) begin
            d = (i < 5) ? regs[0][i+1] : regs[1][1];
            oe[i] = own[i] ? (i == 5 || tmr.oe[ch[i]]) : d;
            out[i] = own[i] ? tmr.val[ch[i]] : ((i < 5) ? regs[9][i+1] : regs[10][1]);
            pu[i] = ~oe[i] & ((i < 3) ? regs[6][4] : (i < 5) ? regs[6][5] : regs[6][6]);
            hd[i] = oe[i] & ((i < 5) ? regs[7][i+1] : regs[8][6]);
            pd[i] = oe[i] ? out[i] : (board_en ? board_val[i] : pu[i]);
            if (own[i] && !d && i < 5) tin[ch[i]] = pd[i];
        end
        return {tin, hd, pu, oe, out};
    endfunction

    task automatic check_pads;
        logic [31:0] e;
        e = expect_pads();
        chk_pin({2'b00, pin_out}, {2'b00, e[5:0]});
        chk_pin({2'b00, pin_oe}, {2'b00, e[11:6]});
        chk_pin({2'b00, pin_pu}, {2'b00, e[17:12]});
        chk_pin({2'b00, pin_hd}, {2'b00, e[23:18]});
        chk_pin(tmr_in, e[31:24]);
    endtask

    // main sequence
    initial begin
        logic [31:0] q;
        logic [7:0] nv [0:10];
        for (int k = 0; k < 11; k++) regs[k] = 8'h00;
        void'($urandom(11));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int k = 0; k < 12; k++) begin
            bus_op(1'b0, 6'(k * 4), 8'h00, 1'b1, q);
            chk_bus(q, 32'h0000_0000);
        end
        check_pads;
        $display("test reset done");
        // writes that must be dropped: lane disabled, unmapped offset
        bus_op(1'b1, 6'h00, 8'h3E, 1'b0, q);
        bus_op(1'b1, 6'h30, 8'hA5, 1'b1, q);
        bus_op(1'b0, 6'h00, 8'h00, 1'b1, q);
        chk_bus(q, 32'h0000_0000);
        bus_op(1'b0, 6'h30, 8'h00, 1'b1, q);
        chk_bus(q, 32'h0000_0000);
        check_pads;
        $display("test refusals done");
        // first four passes are fixed corners, the rest random
        for (int it = 0; it < 40; it++) begin
            for (int k = 0; k < 11; k++) nv[k] = 8'($urandom);
            case (it)
                0: begin
                    nv[2] = 8'h28;
                    nv[4] = 8'h44;
                    nv[0] = 8'h00;
                end
                1: begin
                    nv[2] = 8'h29;
                    nv[4] = 8'h00;
                    nv[3] = 8'h03;
                    nv[5] = 8'h01;
                    nv[0] = 8'h3E;
                    nv[1] = 8'h00;
                end
                2: begin
                    nv[2] = 8'h00;
                    nv[3] = 8'h00;
                    nv[4] = 8'h33;
                    nv[5] = 8'h00;
                end
                3: begin
                    nv[2] = 8'h1C;
                    nv[4] = 8'h55;
                end
                default: ;
            endcase
            for (int k = 0; k < 11; k++) begin
                wr_reg(k, nv[k]);
                bus_op(1'b0, 6'(k * 4), 8'h00, 1'b1, q);
                chk_bus(q, {24'h00_0000, nv[k]});
            end
            tmr <= 16'($urandom);
            board_val <= 6'($urandom);
            repeat (5) @(posedge mclk);
            check_pads;
        end
        $display("test select matrix done");
        // board lets go: only the pull-ups hold the timer inputs high
        for (int k = 0; k < 7; k++) wr_reg(k, (k == 2) ? 8'h29 : (k == 3) ? 8'h03 : 8'h00);
        wr_reg(6, 8'h70);
        tmr <= 16'h0000;
        board_en <= 1'b0;
        repeat (5) @(posedge mclk);
        check_pads;
        bus_op(1'b0, 6'h2C, 8'h00, 1'b1, q);
        chk_bus(q, 32'h0000_003F);
        $display("test pull-up done");
        // reset in mid-run returns every pin to a plain input
        board_en <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 11; k++) regs[k] = 8'h00;
        repeat (4) @(posedge mclk);
        check_pads;
        bus_op(1'b0, 6'h08, 8'h00, 1'b1, q);
        chk_bus(q, 32'h0000_0000);
        $display("test second reset done");
        stop_test;
    end

    // watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        stop_test;
    end
endmodule // pmux_top_tb_top
